//--- common/clk_switch_defines.vh
// clock switch constants: register offsets, field positions, reset values, timing
// assumes inclusion by the clock switch rtl files and testbench only
`ifndef CLK_SWITCH_DEFINES_VH
`define CLK_SWITCH_DEFINES_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OSC_CTRL_OFS 8'h00
`define OSC_STAT_OFS 8'h04
`define OSC_CMD_OFS 8'h08

// ----------------------------------------
// control and command field positions
// ----------------------------------------
`define CTRL_SRC_LO 0
`define CTRL_SRC_HI 1
`define CTRL_IDLE_BIT 2
`define CTRL_DIV_LO 4
`define CTRL_DIV_HI 6
`define CTRL_T1_BIT 8
`define CTRL_WDT_BIT 9
`define CTRL_RCMODE_BIT 10
`define CTRL_RESET 32'h0000_0000
`define CMD_PWRDN_BIT 0
`define CMD_WAKE_BIT 1

// ----------------------------------------
// clock source select codes
// ----------------------------------------
`define SRC_PRI 2'h0
`define SRC_SEC 2'h1
`define SRC_INT 2'h2
`define SRC_INT_ALT 2'h3

// ----------------------------------------
// switch pause in new-clock periods
// ----------------------------------------
`define PAUSE_CYCLES 4'h8
`define PAUSE_CNT_W 4

`endif

//--- rtl/sync_edge.v
// two-flop synchroniser with rising edge output for one oscillator input
// assumes the oscillator is much slower than clk
`include "clk_switch_defines.vh"

module sync_edge (
	clk,
	nrst,
	d,
	level,
	rise
);
	input wire clk;
	input wire nrst;
	input wire d;
	output wire level;
	output wire rise;

	reg s1_r;
	reg s2_r;
	reg s3_r;

	// s1_r feeds s2_r only
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s1_r <= 1'b0;
			s2_r <= 1'b0;
			s3_r <= 1'b0;
		end
		else
		begin
			s1_r <= d;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	assign level = s2_r;
	assign rise = s2_r & ~s3_r;
endmodule

//--- rtl/axil_regs.v
// axi4-lite slave holding control, status and command registers
// assumes one outstanding write and one read from the master
`include "clk_switch_defines.vh"

module axil_regs (
	clk,
	nrst,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	ctrl,
	status,
	pwrdn_pulse,
	wake_pulse
);
	input wire clk;
	input wire nrst;
	input wire [7:0] s_axi_awaddr;
	input wire s_axi_awvalid;
	output wire s_axi_awready;
	input wire [31:0] s_axi_wdata;
	input wire [3:0] s_axi_wstrb;
	input wire s_axi_wvalid;
	output wire s_axi_wready;
	output wire [1:0] s_axi_bresp;
	output reg s_axi_bvalid;
	input wire s_axi_bready;
	input wire [7:0] s_axi_araddr;
	input wire s_axi_arvalid;
	output wire s_axi_arready;
	output reg [31:0] s_axi_rdata;
	output reg [1:0] s_axi_rresp;
	output reg s_axi_rvalid;
	input wire s_axi_rready;
	output reg [31:0] ctrl;
	input wire [31:0] status;
	output reg pwrdn_pulse;
	output reg wake_pulse;

	reg aw_got_r;
	reg w_got_r;
	reg [7:0] awaddr_r;
	reg [31:0] wdata_r;
	reg [3:0] wstrb_r;
	reg bresp_err_r;
	wire aw_fire;
	wire w_fire;
	wire do_write;
	integer i;

	assign s_axi_awready = ~aw_got_r & ~s_axi_bvalid;
	assign s_axi_wready = ~w_got_r & ~s_axi_bvalid;
	assign aw_fire = s_axi_awvalid & s_axi_awready;
	assign w_fire = s_axi_wvalid & s_axi_wready;
	assign do_write = aw_got_r & w_got_r;
	assign s_axi_bresp = bresp_err_r ? 2'h2 : 2'h0;
	assign s_axi_arready = ~s_axi_rvalid;

	// ----------------------------------------
	// write channel
	// ----------------------------------------
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			aw_got_r <= 1'b0;
			w_got_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
			s_axi_bvalid <= 1'b0;
			bresp_err_r <= 1'b0;
			ctrl <= `CTRL_RESET;
			pwrdn_pulse <= 1'b0;
			wake_pulse <= 1'b0;
		end
		else
		begin
			pwrdn_pulse <= 1'b0;
			wake_pulse <= 1'b0;
			if (aw_fire)
			begin
				aw_got_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (w_fire)
			begin
				w_got_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			if (do_write)
			begin
				aw_got_r <= 1'b0;
				w_got_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				bresp_err_r <= 1'b0;
				case ({awaddr_r[7:2], 2'b00})
					`OSC_CTRL_OFS:
					begin
						for (i = 0; i < 4; i = i + 1)
							if (wstrb_r[i])
								ctrl[i*8 +: 8] <= wdata_r[i*8 +: 8];
					end
					`OSC_STAT_OFS:
						bresp_err_r <= 1'b0;
					`OSC_CMD_OFS:
					begin
						pwrdn_pulse <= wstrb_r[0] & wdata_r[`CMD_PWRDN_BIT];
						wake_pulse <= wstrb_r[0] & wdata_r[`CMD_WAKE_BIT];
					end
					default:
						bresp_err_r <= 1'b1;
				endcase
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// read channel
	// ----------------------------------------
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= 2'h0;
			case ({s_axi_araddr[7:2], 2'b00})
				`OSC_CTRL_OFS:
					s_axi_rdata <= ctrl;
				`OSC_STAT_OFS:
					s_axi_rdata <= status;
				`OSC_CMD_OFS:
					s_axi_rdata <= 32'h0000_0000;
				default:
				begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= 2'h2;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end
endmodule

//--- rtl/power_mode_clock_switch.v
// power-managed mode controller and glitch-free system clock switch
// assumes oscillators arrive as slow square waves sampled on clk;
// the system clock is produced as a clk-domain level (clock enable style)
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`include "clk_switch_defines.vh"

module power_mode_clock_switch #(
	parameter DIV_W = 3
) (
	clk,
	nrst,
	s_axi_awaddr,
	s_axi_awvalid,
	s_axi_awready,
	s_axi_wdata,
	s_axi_wstrb,
	s_axi_wvalid,
	s_axi_wready,
	s_axi_bresp,
	s_axi_bvalid,
	s_axi_bready,
	s_axi_araddr,
	s_axi_arvalid,
	s_axi_arready,
	s_axi_rdata,
	s_axi_rresp,
	s_axi_rvalid,
	s_axi_rready,
	primary_osc_in_pin,
	low_power_timer_osc_in,
	fast_internal_osc_in,
	slow_internal_osc_in,
	timer_needs_osc,
	primary_osc_en,
	low_power_timer_osc_en,
	fast_internal_osc_en,
	slow_internal_osc_en,
	primary_osc_out_pin,
	primary_osc_out_pin_oe,
	sys_clk,
	core_clk,
	periph_clk,
	in_sleep
);
	input wire clk;
	input wire nrst;
	input wire [7:0] s_axi_awaddr;
	input wire s_axi_awvalid;
	output wire s_axi_awready;
	input wire [31:0] s_axi_wdata;
	input wire [3:0] s_axi_wstrb;
	input wire s_axi_wvalid;
	output wire s_axi_wready;
	output wire [1:0] s_axi_bresp;
	output wire s_axi_bvalid;
	input wire s_axi_bready;
	input wire [7:0] s_axi_araddr;
	input wire s_axi_arvalid;
	output wire s_axi_arready;
	output wire [31:0] s_axi_rdata;
	output wire [1:0] s_axi_rresp;
	output wire s_axi_rvalid;
	input wire s_axi_rready;
	input wire primary_osc_in_pin;
	input wire low_power_timer_osc_in;
	input wire fast_internal_osc_in;
	input wire slow_internal_osc_in;
	input wire timer_needs_osc;
	output reg primary_osc_en;
	output reg low_power_timer_osc_en;
	output reg fast_internal_osc_en;
	output reg slow_internal_osc_en;
	output reg primary_osc_out_pin;
	output reg primary_osc_out_pin_oe;
	output reg sys_clk;
	output reg core_clk;
	output reg periph_clk;
	output reg in_sleep;

	// ----------------------------------------
	// states
	// ----------------------------------------
	localparam ST_RUN = 2'h0;
	localparam ST_GATE = 2'h1;
	localparam ST_PAUSE = 2'h2;
	localparam ST_SLEEP = 2'h3;

	// src index used by the mux: 0 primary, 1 timer osc, 2 fast internal, 3 slow internal
	localparam NSRC = 4;

	wire [31:0] ctrl;
	wire [31:0] status;
	wire pwrdn_pulse;
	wire wake_pulse;
	wire [NSRC-1:0] src_lvl;
	wire [NSRC-1:0] src_rise;
	wire [1:0] sel_field;
	wire [DIV_W-1:0] div_sel;

	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [1:0] act_src_r;
	reg [1:0] new_src_r;
	reg act_idle_r;
	reg new_idle_r;
	reg pm_active_r;
	reg [`PAUSE_CNT_W-1:0] pause_cnt_r;
	reg [DIV_W-1:0] div_cnt_r;
	reg div_clk_r;
	reg [1:0] quarter_cnt_r;
	reg sel_level;
	reg sel_rise;

	assign sel_field = ctrl[`CTRL_SRC_HI:`CTRL_SRC_LO];
	assign div_sel = ctrl[`CTRL_DIV_LO +: DIV_W];

	// map select field to mux index; slow direct needs its own input so fast can stop
	function [1:0] src_index;
		input [1:0] f;
		begin
			case (f)
				`SRC_PRI: src_index = 2'h0;
				`SRC_SEC: src_index = 2'h1;
				default: src_index = f;
			endcase
		end
	endfunction

	// ----------------------------------------
	// oscillator synchronisers
	// ----------------------------------------
	genvar g;
	generate
		for (g = 0; g < NSRC; g = g + 1)
		begin : g_sync
			wire raw;
			if (g == 0)
				assign raw = primary_osc_in_pin;
			else if (g == 1)
				assign raw = low_power_timer_osc_in;
			else if (g == 2)
				assign raw = div_sel == {DIV_W{1'b0}} ? fast_internal_osc_in : div_clk_r;
			else
				assign raw = slow_internal_osc_in;
			sync_edge u_sync (
				.clk(clk),
				.nrst(nrst),
				.d(raw),
				.level(src_lvl[g]),
				.rise(src_rise[g])
			);
		end
	endgenerate

	// ----------------------------------------
	// register slave
	// ----------------------------------------
	assign status = {24'h000000, in_sleep, act_idle_r, pm_active_r, state_r, 1'b0, act_src_r};

	axil_regs u_regs (
		.clk(clk),
		.nrst(nrst),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.ctrl(ctrl),
		.status(status),
		.pwrdn_pulse(pwrdn_pulse),
		.wake_pulse(wake_pulse)
	);

	// ----------------------------------------
	// internal divider, counts raw fast edges
	// ----------------------------------------
	reg fast_d1_r;
	reg fast_d2_r;
	reg fast_d3_r;
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			fast_d1_r <= 1'b0;
			fast_d2_r <= 1'b0;
			fast_d3_r <= 1'b0;
			div_cnt_r <= {DIV_W{1'b0}};
			div_clk_r <= 1'b0;
		end
		else
		begin
			fast_d1_r <= fast_internal_osc_in;
			fast_d2_r <= fast_d1_r;
			fast_d3_r <= fast_d2_r;
			if (fast_d2_r && !fast_d3_r)
			begin
				if (div_cnt_r >= div_sel)
				begin
					div_cnt_r <= {DIV_W{1'b0}};
					div_clk_r <= ~div_clk_r;
				end
				else
					div_cnt_r <= div_cnt_r + {{(DIV_W-1){1'b0}}, 1'b1};
			end
		end
	end

	// ----------------------------------------
	// selected source views
	// ----------------------------------------
	always @*
	begin
		sel_level = 1'b0;
		sel_rise = 1'b0;
		case (state_r)
			ST_PAUSE:
			begin
				sel_level = src_lvl[new_src_r];
				sel_rise = src_rise[new_src_r];
			end
			default:
			begin
				sel_level = src_lvl[act_src_r];
				sel_rise = src_rise[act_src_r];
			end
		endcase
	end

	// ----------------------------------------
	// mode state machine
	// ----------------------------------------
	always @*
	begin
		state_nxt = state_r;
		case (state_r)
			ST_RUN:
				if (pwrdn_pulse)
					state_nxt = ST_GATE;
			ST_GATE:
				if (!sel_level)
					state_nxt = sleep_sel(new_idle_r, pm_active_r) ? ST_SLEEP : ST_PAUSE;
			ST_PAUSE:
				if (sel_rise && pause_cnt_r == `PAUSE_CYCLES)
					state_nxt = ST_RUN;
			ST_SLEEP:
				if (wake_pulse)
					state_nxt = ST_PAUSE;
			default:
				state_nxt = ST_RUN;
		endcase
	end

	// sleep: idle bit set with primary select means the primary idle mode,
	// so sleep is taken as idle bit clear on a power-down command
	function sleep_sel;
		input idle;
		input pm;
		begin
			sleep_sel = pm & ~idle;
		end
	endfunction

	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			state_r <= ST_RUN;
			act_src_r <= 2'h0;
			new_src_r <= 2'h0;
			act_idle_r <= 1'b0;
			new_idle_r <= 1'b0;
			pm_active_r <= 1'b0;
			pause_cnt_r <= {`PAUSE_CNT_W{1'b0}};
		end
		else
		begin
			state_r <= state_nxt;
			if (state_r == ST_RUN && pwrdn_pulse)
			begin
				new_src_r <= src_index(sel_field);
				new_idle_r <= ctrl[`CTRL_IDLE_BIT];
				pm_active_r <= 1'b1;
			end
			if (state_r == ST_SLEEP && wake_pulse)
			begin
				new_src_r <= 2'h0;
				new_idle_r <= 1'b0;
				pm_active_r <= 1'b0;
			end
			if (state_r == ST_GATE && state_nxt == ST_SLEEP)
				act_idle_r <= 1'b1;
			if (state_r == ST_GATE || state_r == ST_SLEEP)
				pause_cnt_r <= {`PAUSE_CNT_W{1'b0}};
			else if (state_r == ST_PAUSE && sel_rise && pause_cnt_r != `PAUSE_CYCLES)
				pause_cnt_r <= pause_cnt_r + {{(`PAUSE_CNT_W-1){1'b0}}, 1'b1};
			if (state_r == ST_PAUSE && state_nxt == ST_RUN)
			begin
				act_src_r <= new_src_r;
				act_idle_r <= new_idle_r;
			end
		end
	end

	// ----------------------------------------
	// oscillator enables and clock outputs
	// ----------------------------------------
	always @(posedge clk or negedge nrst)
	begin
		if (!nrst)
		begin
			primary_osc_en <= 1'b1;
			low_power_timer_osc_en <= 1'b0;
			fast_internal_osc_en <= 1'b0;
			slow_internal_osc_en <= 1'b0;
			in_sleep <= 1'b0;
			sys_clk <= 1'b0;
			core_clk <= 1'b0;
			periph_clk <= 1'b0;
			quarter_cnt_r <= 2'h0;
			primary_osc_out_pin <= 1'b0;
			primary_osc_out_pin_oe <= 1'b0;
		end
		else
		begin
			in_sleep <= state_r == ST_SLEEP;
			// primary only survives in primary idle or plain run
			primary_osc_en <= state_r != ST_SLEEP &&
				(!pm_active_r || (new_src_r == 2'h0 && new_idle_r));
			low_power_timer_osc_en <= ctrl[`CTRL_T1_BIT] | timer_needs_osc |
				(state_r != ST_SLEEP && (new_src_r == 2'h1 || act_src_r == 2'h1));
			fast_internal_osc_en <= state_r != ST_SLEEP && (new_src_r == 2'h2 || act_src_r == 2'h2);
			slow_internal_osc_en <= ctrl[`CTRL_WDT_BIT] |
				(state_r != ST_SLEEP && (new_src_r == 2'h3 || act_src_r == 2'h3));
			// pause and gate phases hold the clock low: no runt pulse
			sys_clk <= state_r == ST_RUN && sel_level;
			periph_clk <= state_r == ST_RUN && sel_level;
			core_clk <= state_r == ST_RUN && sel_level && !(pm_active_r && act_idle_r);
			if (src_rise[0])
				quarter_cnt_r <= quarter_cnt_r + 2'h1;
			primary_osc_out_pin_oe <= ctrl[`CTRL_RCMODE_BIT];
			primary_osc_out_pin <= ctrl[`CTRL_RCMODE_BIT] & quarter_cnt_r[1];
		end
	end
endmodule

//--- test/power_mode_clock_switch_props.sv
// concurrent checks on the clock switch top ports
// assumes every oscillator input runs well below clk
module power_mode_clock_switch_props (
	input wire clk,
	input wire nrst,
	input wire s_axi_awready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	input wire primary_osc_en,
	input wire fast_internal_osc_en,
	input wire sys_clk,
	input wire core_clk,
	input wire periph_clk,
	input wire in_sleep
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!nrst);
	// ----------------------------------------
	// wake steps: leave sleep, hold the pause, resume
	// ----------------------------------------
	sequence wake_s;
		$fell(in_sleep);
	endsequence
	sequence pause_s;
		!sys_clk [*8];
	endsequence
	a_sleep_clk_off: assert property (in_sleep |-> !sys_clk && !core_clk && !periph_clk)
		else $error("clock running while asleep");
	a_sleep_osc_off: assert property (in_sleep |-> !primary_osc_en && !fast_internal_osc_en)
		else $error("oscillator left running while asleep");
	a_wake_pause_min: assert property (wake_s |-> pause_s)
		else $error("system clock resumed before the pause");
	a_wake_pause_max: assert property (wake_s |-> ##[1:400] sys_clk)
		else $error("system clock did not resume after wake");
	a_core_in_periph: assert property (core_clk |-> periph_clk)
		else $error("core clocked without peripherals");
	a_periph_in_sys: assert property (periph_clk |-> sys_clk)
		else $error("peripheral clock outside system clock");
	a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped early");
	a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rresp) && s_axi_rvalid)
		else $error("read response dropped early");
	a_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && (s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2))
		else $error("write taken while response pending");
endmodule

bind power_mode_clock_switch power_mode_clock_switch_props props_i (.clk, .nrst, .s_axi_awready, .s_axi_bresp,
	.s_axi_bvalid, .s_axi_bready, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .primary_osc_en,
	.fast_internal_osc_en, .sys_clk, .core_clk, .periph_clk, .in_sleep);

//--- test/power_mode_clock_switch_tb.sv
// self-checking bench for the power mode clock switch
// assumes the defines header is on the include path
`include "clk_switch_defines.vh"
module power_mode_clock_switch_tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int PRI_P = 10;
	localparam int SETTLE = 9 * 14 + 40;
	// divided internal source: up to 8 fast edges per half period, 6 clk per fast period
	localparam int INT_SETTLE = 9 * 2 * 8 * 6 + 40;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic primary_osc_in_pin = 1'b0, low_power_timer_osc_in = 1'b0, fast_internal_osc_in = 1'b0;
	logic slow_internal_osc_in = 1'b0, timer_needs_osc = 1'b0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire primary_osc_en, low_power_timer_osc_en, fast_internal_osc_en, slow_internal_osc_en;
	wire primary_osc_out_pin, primary_osc_out_pin_oe, sys_clk, core_clk, periph_clk, in_sleep;
	int error_cnt = 0;
	int cmp_count = 0;
	int n_core, n_per, n_in, n_out, pri_low, c;
	logic [31:0] rdv, exp_ctrl;
	logic [1:0] resp;
	// oscillator edges fall on clk falling edges, never on rising ones
	always #5 clk = ~clk;
	always #50 primary_osc_in_pin = ~primary_osc_in_pin;
	always #70 low_power_timer_osc_in = ~low_power_timer_osc_in;
	always #30 fast_internal_osc_in = ~fast_internal_osc_in;
	always #110 slow_internal_osc_in = ~slow_internal_osc_in;
	power_mode_clock_switch DUT (.clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.primary_osc_in_pin, .low_power_timer_osc_in, .fast_internal_osc_in, .slow_internal_osc_in,
		.timer_needs_osc, .primary_osc_en, .low_power_timer_osc_en, .fast_internal_osc_en, .slow_internal_osc_en,
		.primary_osc_out_pin, .primary_osc_out_pin_oe, .sys_clk, .core_clk, .periph_clk, .in_sleep);
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		n = 0;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			aw = aw && !s_axi_awready;
			w = w && !s_axi_wready;
			s_axi_awvalid <= aw;
			s_axi_wvalid <= w;
		end while (s_axi_bvalid !== 1'b1 && n < 300);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		chk(n < 300, 1);
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic ar;
		ar = 1'b1;
		n = 0;
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do
		begin
			@(posedge clk);
			n++;
			ar = ar && !s_axi_arready;
			s_axi_arvalid <= ar;
		end while (s_axi_rvalid !== 1'b1 && n < 300);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
		chk(n < 300, 1);
	endtask
	task automatic rst();
		@(posedge clk);
		nrst <= 1'b0;
		timer_needs_osc <= 1'b0;
		repeat (8) @(posedge clk);
		chk({primary_osc_en, low_power_timer_osc_en, fast_internal_osc_en, slow_internal_osc_en,
			primary_osc_out_pin_oe, sys_clk, core_clk, periph_clk, in_sleep}, 9'h100);
		nrst <= 1'b1;
		pri_low = 0;
	endtask
	// ctrl is staged first so the command sees the new selection
	task automatic pd(input logic [31:0] v);
		wr(`OSC_CTRL_OFS, v, resp);
		exp_ctrl = v;
		wr(`OSC_CMD_OFS, 32'h1, resp);
	endtask
	task automatic watch(input int cyc);
		logic pc, pp, pi, po;
		n_core = 0;
		n_per = 0;
		n_in = 0;
		n_out = 0;
		{pc, pp, pi, po} = {core_clk, periph_clk, primary_osc_in_pin, primary_osc_out_pin};
		repeat (cyc)
		begin
			@(posedge clk);
			n_core += int'(core_clk && !pc);
			n_per += int'(periph_clk && !pp);
			n_in += int'(primary_osc_in_pin && !pi);
			n_out += int'(primary_osc_out_pin && !po);
			pri_low += int'(primary_osc_en !== 1'b1);
			{pc, pp, pi, po} = {core_clk, periph_clk, primary_osc_in_pin, primary_osc_out_pin};
		end
	endtask
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		error_cnt++;
		give_verdict();
	end
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial
	begin
		void'($urandom(32'h53e1));
		rst();
		rd(`OSC_CTRL_OFS, rdv, resp);
		chk(rdv, `CTRL_RESET);
		exp_ctrl = $urandom & 32'h777;
		wr(`OSC_CTRL_OFS, exp_ctrl, resp);
		rd(`OSC_CTRL_OFS, rdv, resp);
		chk(rdv, exp_ctrl);
		wr(`OSC_STAT_OFS, 32'hff, resp);
		rd(`OSC_STAT_OFS, rdv, resp);
		chk(rdv[1:0], `SRC_PRI);
		wr(8'h0c, 32'h1, resp);
		chk(resp, 2'h2);
		rd(8'h10, rdv, resp);
		chk(resp, 2'h2);
		$display("test registers done");
		rst();
		pd(32'h5);
		watch(SETTLE);
		rd(`OSC_STAT_OFS, rdv, resp);
		chk({rdv[7:5], rdv[1:0]}, {3'b011, `SRC_SEC});
		chk({primary_osc_en, low_power_timer_osc_en}, 2'b01);
		watch(200);
		chk(n_core, 0);
		chk(n_per > 0, 1);
		$display("test secondary idle done");
		rst();
		pd(32'h4);
		watch(SETTLE);
		watch(200);
		chk(pri_low, 0);
		chk({n_core == 0, n_per > 0}, 2'b11);
		$display("test primary idle done");
		rst();
		pd(32'h6 | ({$urandom} % 8) << 4);
		watch(INT_SETTLE);
		chk(fast_internal_osc_en, 1'b1);
		rd(`OSC_STAT_OFS, rdv, resp);
		chk(rdv[1:0], `SRC_INT);
		watch(200);
		chk(n_per > 0, 1);
		pd(32'h7);
		watch(INT_SETTLE);
		chk({fast_internal_osc_en, slow_internal_osc_en}, 2'b01);
		rd(`OSC_STAT_OFS, rdv, resp);
		chk(rdv[1:0], `SRC_INT_ALT);
		watch(200);
		chk(n_per > 0, 1);
		$display("test internal modes done");
		rst();
		timer_needs_osc <= 1'b1;
		pd(32'h200);
		watch(SETTLE);
		chk({in_sleep, primary_osc_en, fast_internal_osc_en}, 3'b100);
		chk(slow_internal_osc_en, 1'b1);
		chk(low_power_timer_osc_en, 1'b1);
		watch(200);
		chk(n_per, 0);
		wr(`OSC_CMD_OFS, 32'h2, resp);
		c = 0;
		while (sys_clk !== 1'b1 && c < 300)
		begin
			@(posedge clk);
			c++;
		end
		chk(c >= 8 * PRI_P - 3 && c <= 9 * PRI_P + 6, 1);
		chk(in_sleep, 1'b0);
		$display("test sleep and wake done");
		rst();
		wr(`OSC_CTRL_OFS, 32'h400, resp);
		watch(400);
		chk(primary_osc_out_pin_oe, 1'b1);
		chk(n_out * 4 >= n_in - 4 && n_out * 4 <= n_in + 4, 1);
		$display("test quarter rate output done");
		give_verdict();
	end
endmodule
